// ---- include/qot_pkg.sv ----
// package for the quadrature and one-shot timer channel
// assumes a 100 MHz system clock and a 32-bit avalon-mm slave port
package qot_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [3:0] ADDR_COUNT = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // ****************************************
    // control and status register fields
    // ****************************************
    localparam int CTRL_START = 0;
    localparam int CTRL_OS_START = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_FREE_RUN = 3;
    localparam int CTRL_X4 = 4;
    localparam int CTRL_CLK_LO = 5;
    localparam int CTRL_CLK_HI = 6;
    localparam int CTRL_TRIG_EXT = 7;
    localparam int CTRL_TRIG_OVF = 8;
    localparam int CTRL_PULSE_EN = 9;

    localparam int STAT_RUN = 0;
    localparam int STAT_IRQ = 1;

    // ****************************************
    // constants
    // ****************************************
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_SUB32 = 2'h3;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1f;

    // processing per channel
    localparam logic [1:0] PROC_SELECT = 2'h0;
    localparam logic [1:0] PROC_NORMAL = 2'h1;
    localparam logic [1:0] PROC_X4 = 2'h2;

    typedef enum logic [1:0] {
        QOT_IDLE = 2'b01,
        QOT_RUN = 2'b10
    } qot_state_e;

endpackage : qot_pkg

// ---- hw/qot_timer.sv ----
// quadrature event counter / one-shot timer channel with avalon-mm registers
// assumes pins synchronous-sampled here, subclock_div32 a one-cycle tick input
`timescale 1ns/1ps
`default_nettype none

// Function
// - two-phase mode counts from input pin and output pin, both used as inputs
// - direction from phase relation; over/underflow loads reload value unless free-run
// - divide by ffff-n+1 counting up, n+1 counting down
// - two-phase counting only while start flag is one
// - two-phase mode raises interrupt on every overflow or underflow
// - counter read in two-phase mode returns current count
// - write stopped loads reload and counter; running loads reload only
// - normal: with out pin high, in rising counts up, falling down
// - x4: every edge of both pins counts, direction from phase
// - channel three selectable; two and seven normal; four fixed x4
// - one-shot counts down, at zero reloads and stops; period n clocks
// - trigger during one-shot count reloads and restarts
// - one-shot starts on external trigger, timer overflow or software flag
// - one-shot stops after reload at zero or start flag cleared
// - one-shot interrupt when count reaches zero
// - counter read in one-shot mode is undefined
// - one-shot in pin is trigger input, out pin pulse output
// - free-run suppresses automatic reload in two-phase counting
// - free-run counter wraps through over/underflow without reload
module qot_timer #(
    parameter logic [1:0] PROC_KIND = qot_pkg::PROC_SELECT
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic timer_in_pin_i,
    input wire logic timer_out_pin_i,
    output logic timer_out_pin_o,
    output logic timer_out_pin_oe_o,
    input wire logic subclock_div32_i,
    input wire logic ext_overflow_i,
    output logic irq_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        qot_pkg::qot_state_e st;
        logic [15:0] cnt;
        logic [15:0] rld;
        logic [9:0] ctrl;
        logic irq;
        logic pulse;
        logic [1:0] in_s;
        logic [1:0] out_s;
        logic in_p;
        logic out_p;
        logic [1:0] warm;
        logic [4:0] pre;
        logic [31:0] rdata;
        logic ack;
    } qot_state_s;

    qot_state_s q;
    qot_state_s d;

    logic in_rise;
    logic in_fall;
    logic out_rise;
    logic out_fall;
    logic x4_sel;
    logic up_ev;
    logic dn_ev;
    logic tick;
    logic trig;
    logic os_mode;
    logic wr_cnt;
    logic wr_ctrl;
    logic primed;

    // ****************************************
    // edge detection on synchronised pins
    // ****************************************
    // only the second stage is looked at, the first is metastability guard
    // edges masked until sync stages and history hold real pin levels,
    // else a pin resting high would count once after reset
    assign primed = &q.warm;
    assign in_rise = primed & q.in_s[1] & ~q.in_p;
    assign in_fall = primed & ~q.in_s[1] & q.in_p;
    assign out_rise = primed & q.out_s[1] & ~q.out_p;
    assign out_fall = primed & ~q.out_s[1] & q.out_p;

    always_comb begin
        case (PROC_KIND)
            qot_pkg::PROC_X4: x4_sel = 1'b1;
            qot_pkg::PROC_NORMAL: x4_sel = 1'b0;
            default: x4_sel = q.ctrl[qot_pkg::CTRL_X4];
        endcase
    end

    always_comb begin
        if (x4_sel) begin
            // phase: out leads in means up
            up_ev = (in_rise & q.out_s[1]) | (in_fall & ~q.out_s[1])
                | (out_rise & ~q.in_s[1]) | (out_fall & q.in_s[1]);
            dn_ev = (in_fall & q.out_s[1]) | (in_rise & ~q.out_s[1])
                | (out_rise & q.in_s[1]) | (out_fall & ~q.in_s[1]);
        end else begin
            up_ev = in_rise & q.out_s[1];
            dn_ev = in_fall & q.out_s[1];
        end
    end

    // ****************************************
    // one-shot count clock
    // ****************************************
    always_comb begin
        case (q.ctrl[qot_pkg::CTRL_CLK_HI:qot_pkg::CTRL_CLK_LO])
            qot_pkg::CLK_DIV1: tick = 1'b1;
            qot_pkg::CLK_DIV8: tick = (q.pre[2:0] == qot_pkg::DIV8_LAST[2:0]);
            qot_pkg::CLK_DIV32: tick = (q.pre == qot_pkg::DIV32_LAST);
            qot_pkg::CLK_SUB32: tick = subclock_div32_i;
            default: tick = 1'b0;
        endcase
    end

    assign os_mode = q.ctrl[qot_pkg::CTRL_MODE];
    // writes land on the edge that ends the ack cycle after the wait state, never earlier
    assign wr_cnt = avs_write_i & (avs_address_i == qot_pkg::ADDR_COUNT) & q.ack;
    assign wr_ctrl = avs_write_i & (avs_address_i == qot_pkg::ADDR_CTRL) & q.ack;
    assign trig = (q.ctrl[qot_pkg::CTRL_TRIG_EXT] & in_rise)
        | (q.ctrl[qot_pkg::CTRL_TRIG_OVF] & ext_overflow_i)
        | (wr_ctrl & avs_byteenable_i[0] & avs_writedata_i[qot_pkg::CTRL_OS_START]);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.in_s = {q.in_s[0], timer_in_pin_i};
        d.out_s = {q.out_s[0], timer_out_pin_i};
        d.in_p = q.in_s[1];
        d.out_p = q.out_s[1];
        if (!primed) begin
            d.warm = q.warm + 2'h1;
        end
        d.pre = q.pre + 5'h01;
        d.irq = 1'b0;
        d.ack = 1'b0;
        d.rdata = 32'h0000_0000;

        // ****************************************
        // two-phase counting
        // ****************************************
        if (!os_mode) begin
            d.st = qot_pkg::QOT_IDLE;
            d.pulse = 1'b0;
            if (q.ctrl[qot_pkg::CTRL_START] && (up_ev ^ dn_ev)) begin
                if (up_ev) begin
                    if (q.cnt == qot_pkg::CNT_MAX) begin
                        d.irq = 1'b1;
                        // up from n takes ffff-n+1 events to wrap
                        d.cnt = q.ctrl[qot_pkg::CTRL_FREE_RUN]
                            ? qot_pkg::CNT_ZERO : q.rld;
                    end else begin
                        d.cnt = q.cnt + qot_pkg::CNT_ONE;
                    end
                end else begin
                    if (q.cnt == qot_pkg::CNT_ZERO) begin
                        d.irq = 1'b1;
                        d.cnt = q.ctrl[qot_pkg::CTRL_FREE_RUN]
                            ? qot_pkg::CNT_MAX : q.rld;
                    end else begin
                        d.cnt = q.cnt - qot_pkg::CNT_ONE;
                    end
                end
            end
        end else begin
            // ****************************************
            // one-shot
            // ****************************************
            case (q.st)
                qot_pkg::QOT_IDLE: begin
                    d.pulse = 1'b0;
                    // start flag must be set, a bare trigger would give a one-cycle pulse
                    if (trig && q.ctrl[qot_pkg::CTRL_START]
                        && q.rld != qot_pkg::CNT_ZERO) begin
                        d.st = qot_pkg::QOT_RUN;
                        d.cnt = q.rld;
                        d.pulse = 1'b1;
                        // prescaler restarts so the first count clock is a whole one
                        d.pre = '0;
                    end
                end
                qot_pkg::QOT_RUN: begin
                    if (!q.ctrl[qot_pkg::CTRL_START]) begin
                        d.st = qot_pkg::QOT_IDLE;
                        d.pulse = 1'b0;
                    end else if (trig) begin
                        d.cnt = q.rld;
                        d.pre = '0;
                    end else if (tick) begin
                        if (q.cnt == qot_pkg::CNT_ONE) begin
                            // n ticks from load to zero
                            d.irq = 1'b1;
                            d.cnt = q.rld;
                            d.st = qot_pkg::QOT_IDLE;
                            d.pulse = 1'b0;
                        end else begin
                            d.cnt = q.cnt - qot_pkg::CNT_ONE;
                        end
                    end
                end
                default: begin
                    d.st = qot_pkg::QOT_IDLE;
                end
            endcase
        end

        // ****************************************
        // register access, one wait state
        // ****************************************
        if ((avs_read_i || avs_write_i) && !q.ack) begin
            d.ack = 1'b1;
        end
        if (wr_cnt) begin
            if (avs_byteenable_i[0]) begin
                d.rld[7:0] = avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
                d.rld[15:8] = avs_writedata_i[15:8];
            end
            // running loads reload only; next reload moves it in
            if (!q.ctrl[qot_pkg::CTRL_START] || (os_mode && q.st == qot_pkg::QOT_IDLE)) begin
                d.cnt = d.rld;
            end
        end
        if (wr_ctrl) begin
            if (avs_byteenable_i[0]) begin
                d.ctrl[7:0] = avs_writedata_i[7:0];
                d.ctrl[qot_pkg::CTRL_OS_START] = 1'b0;
            end
            if (avs_byteenable_i[1]) begin
                d.ctrl[9:8] = avs_writedata_i[9:8];
            end
        end
        if (avs_read_i && !q.ack) begin
            case (avs_address_i)
                // one-shot count reads are not meaningful to software
                qot_pkg::ADDR_COUNT: d.rdata = {16'h0000, q.cnt};
                qot_pkg::ADDR_CTRL: d.rdata = {22'h000000, q.ctrl};
                qot_pkg::ADDR_STATUS: begin
                    d.rdata[qot_pkg::STAT_RUN] = (q.st == qot_pkg::QOT_RUN);
                    d.rdata[qot_pkg::STAT_IRQ] = q.irq;
                end
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q <= '0;
            q.st <= qot_pkg::QOT_IDLE;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
    assign avs_readdata_o = q.rdata;
    assign irq_o = q.irq;
    assign timer_out_pin_o = q.pulse;
    // out pin is an input in two-phase mode
    assign timer_out_pin_oe_o = os_mode & q.ctrl[qot_pkg::CTRL_PULSE_EN];

endmodule : qot_timer

`default_nettype wire

// ---- tb/qot_timer_props.sv ----
// port checks for qot_timer
// assumes one clock domain, bound to every qot_timer instance
`timescale 1ns/1ps
`default_nettype none
module qot_timer_props (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic timer_out_pin_oe_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    wire logic acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
    wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("no wait state in first request cycle");
    wait_second_a: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait state longer than one cycle");
    wait_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
        else $error("waitrequest without request");
    rdata_idle_a: assert property (!(acc && avs_read_i) |-> avs_readdata_o == 32'h0)
        else $error("read data outside read answer");
    upper_zero_a: assert property (acc && avs_read_i |-> avs_readdata_o[31:16] == 16'h0)
        else $error("upper read lanes not zero");
    irq_pulse_a: assert property (irq_o |=> !irq_o)
        else $error("irq longer than one cycle");
    os_flag_a: assert property (acc && avs_read_i && avs_address_i == qot_pkg::ADDR_CTRL
        |-> !avs_readdata_o[qot_pkg::CTRL_OS_START]) else $error("soft start flag reads one");
    oe_ctrl_a: assert property (acc && avs_write_i && avs_address_i == qot_pkg::ADDR_CTRL
        |=> timer_out_pin_oe_o == ($past(avs_writedata_i[qot_pkg::CTRL_PULSE_EN])
        && $past(avs_writedata_i[qot_pkg::CTRL_MODE]))) else $error("pin enable wrong");
endmodule : qot_timer_props
bind qot_timer qot_timer_props u_props (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .timer_out_pin_oe_o(timer_out_pin_oe_o), .irq_o(irq_o));
`default_nettype wire

// ---- tb/qot_encoder_model.sv ----
// two-phase encoder facing the timer pins
// assumes one step_i pulse per quarter step
`timescale 1ns/1ps
`default_nettype none
module qot_encoder_model (
    input wire logic clk_i,
    input wire logic step_i,
    input wire logic up_i,
    output logic in_o,
    output logic out_o
);
    logic [1:0] ph_q = 2'h0;
    always @(posedge clk_i) begin
        if (step_i) begin
            ph_q <= up_i ? ph_q + 2'h1 : ph_q - 2'h1;
        end
    end
    // gray steps: one pin per step, out pin leads when stepping up
    assign in_o = ph_q[1];
    assign out_o = ph_q[1] ^ ph_q[0];
endmodule : qot_encoder_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for qot_timer: register table, then counting cases
// assumes qot_encoder_model on both pins, byteenable held full
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} qot_row_s;
    logic clk_i = 1'b0, srst_i = 1'b1, rd = 1'b0, wr = 1'b0, step = 1'b0, up = 1'b0, ovf = 1'b0;
    logic [3:0] addr = 4'h0;
    logic sub = 1'b0;
    logic [31:0] wd = 32'h0, rdata, q, rdata_n, qn;
    logic wait_o, in_p, out_p, pin_o, pin_oe, irq;
    int errors = 0, checked = 0, irqs = 0, cyc = 0, prev;
    qot_row_s rows [9] = '{
        '{1'b0, 4'h0, 32'h0, 32'h0}, '{1'b0, 4'h4, 32'h0, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'h0},
        '{1'b1, 4'hc, 32'hffff, 32'h0}, '{1'b0, 4'hc, 32'h0, 32'h0},
        '{1'b1, 4'h8, 32'h3, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'h0},
        '{1'b1, 4'h0, 32'h1234, 32'h0}, '{1'b0, 4'h0, 32'h0, 32'h1234}};
    // pin level: timer drives it in pulse mode, encoder otherwise
    wire logic out_w = pin_oe ? pin_o : out_p;
    qot_timer u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_o), .timer_in_pin_i(in_p), .timer_out_pin_i(out_w),
        .timer_out_pin_o(pin_o), .timer_out_pin_oe_o(pin_oe), .subclock_div32_i(sub),
        .ext_overflow_i(ovf), .irq_o(irq));
    // fixed normal channel beside the selectable one, same bus and pins
    qot_timer #(.PROC_KIND(qot_pkg::PROC_NORMAL)) u_dut_norm (
        .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata_n),
        .avs_waitrequest_o(), .timer_in_pin_i(in_p), .timer_out_pin_i(out_w),
        .timer_out_pin_o(), .timer_out_pin_oe_o(), .subclock_div32_i(sub),
        .ext_overflow_i(ovf), .irq_o());
    qot_encoder_model u_enc (.clk_i(clk_i), .step_i(step), .up_i(up), .in_o(in_p), .out_o(out_p));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irqs <= irqs + 1;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // held until waitrequest sampled low, released after that edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk_i);
        while (wait_o !== 1'b0) @(posedge clk_i);
        q = rdata;
        qn = rdata_n;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask : rdc
    // gaps cover the two-flop sync plus edge detect
    task automatic steps(input logic u, input int n);
        repeat (n) begin
            @(posedge clk_i);
            step <= 1'b1;
            up <= u;
            @(posedge clk_i);
            step <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
    endtask : steps
    task automatic kick(input int gap);
        @(posedge clk_i);
        ovf <= 1'b1;
        @(posedge clk_i);
        ovf <= 1'b0;
        repeat (gap) @(posedge clk_i);
    endtask : kick
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
            else rdc(rows[i].a, rows[i].e, "table read");
        end
        bus(1'b1, 4'h0, 32'hfffe);
        bus(1'b1, 4'h4, 32'h1);
        steps(1'b1, 8);
        rdc(4'h0, 32'hfffe, "up wrap");
        chk("up irq", 32'h1, irqs);
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b1, 4'h4, 32'h11);
        steps(1'b0, 1);
        bus(1'b1, 4'h0, 32'h5);
        rdc(4'h0, 32'h1, "x4 down");
        chk("fixed normal", 32'h2, qn);
        steps(1'b0, 2);
        rdc(4'h0, 32'h5, "x4 reload");
        bus(1'b1, 4'h4, 32'h10);
        steps(1'b0, 2);
        rdc(4'h0, 32'h5, "halted");
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h4, 32'h19);
        steps(1'b0, 1);
        rdc(4'h0, 32'hffff, "free run");
        chk("two-phase irqs", 32'h3, irqs);
        bus(1'b1, 4'h4, 32'h0);
        bus(1'b1, 4'h0, 32'h3);
        bus(1'b1, 4'h4, 32'h205);
        prev = irqs;
        bus(1'b1, 4'h4, 32'h207);
        @(posedge clk_i);
        chk("pulse out", 32'h1, {31'h0, pin_o});
        repeat (10) @(posedge clk_i);
        chk("one-shot irq", prev + 1, irqs);
        chk("pulse end", 32'h0, {31'h0, pin_o});
        chk("pulse oe", 32'h1, {31'h0, pin_oe});
        rdc(4'h8, 32'h0, "idle status");
        bus(1'b1, 4'h4, 32'h105);
        kick(10);
        chk("ovf trigger", prev + 2, irqs);
        bus(1'b1, 4'h4, 32'h85);
        steps(1'b1, 4);
        repeat (4) @(posedge clk_i);
        chk("pin trigger", prev + 3, irqs);
        bus(1'b1, 4'h0, 32'h100);
        bus(1'b1, 4'h4, 32'h105);
        kick(2);
        bus(1'b1, 4'h4, 32'h104);
        rdc(4'h8, 32'h0, "cleared status");
        repeat (300) @(posedge clk_i);
        chk("cleared irq", prev + 3, irqs);
        bus(1'b1, 4'h0, 32'h10);
        bus(1'b1, 4'h4, 32'h105);
        kick(10);
        kick(10);
        chk("restart", prev + 3, irqs);
        repeat (10) @(posedge clk_i);
        chk("restart irq", prev + 4, irqs);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b1, 4'h4, 32'h27);
        repeat (12) @(posedge clk_i);
        chk("div8 early", prev + 4, irqs);
        repeat (12) @(posedge clk_i);
        chk("div8 irq", prev + 5, irqs);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b1, 4'h4, 32'h47);
        repeat (40) @(posedge clk_i);
        chk("div32 early", prev + 5, irqs);
        repeat (40) @(posedge clk_i);
        chk("div32 irq", prev + 6, irqs);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b1, 4'h4, 32'h67);
        repeat (40) @(posedge clk_i);
        chk("sub early", prev + 6, irqs);
        repeat (2) begin
            @(posedge clk_i);
            sub <= 1'b1;
            @(posedge clk_i);
            sub <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        chk("sub irq", prev + 7, irqs);
        srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rdc(4'h4, 32'h0, "ctrl reset");
        rdc(4'h0, 32'h0, "count reset");
        close_out();
    end
endmodule : testbench
`default_nettype wire
